// ==== verilog/scr_defines.svh ====
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Status word layout.
`define SCR_RESP_LSB       3
`define SCR_LOCK_BIT       2
`define SCR_STAT_HI        9'h0FF
`define SCR_STAT_LO        2'h0

// Response codes.
`define SCR_RESP_NULL      4'h1
`define SCR_RESP_LOCK      4'h2
`define SCR_RESP_UNLOCK    4'h3
`define SCR_RESP_REGISTER_READ_CMD      4'h4
`define SCR_RESP_RREG2     4'h5
`define SCR_RESP_REGISTER_WRITE_CMD      4'h6
`define SCR_RESP_FIRST     4'h9
`define SCR_RESP_ERR       4'hA
`define SCR_RESP_RST       4'h9
`define SCR_LOCK_RST       1'b0

// Command words.
`define SCR_CMD_NULL       16'h0000
`define SCR_CMD_RESET      16'h0011
`define SCR_CMD_LOCK       16'h0555
`define SCR_CMD_UNLOCK     16'h0655
`define SCR_OP_REGISTER_READ_CMD        3'h5
`define SCR_OP_REGISTER_WRITE_CMD        3'h3

// Serial clocks needed to complete each kind of frame.
`define SCR_BITS_CMD       7'h20
`define SCR_BITS_REGISTER_WRITE_CMD      7'h40
`define SCR_BITS_FRAME     7'h50
`define SCR_BITS_RX        7'h40
`define SCR_BITS_MAX       7'h7F

// Word protection.
`define SCR_CRC_INIT       16'hFFFF
`define SCR_CRC_POLY       16'h1021

// Interface timeout.
`define SCR_TIMEOUT_NS     20000
`define SCR_CLK_PERIOD_NS  5
`define SCR_TIMEOUT_CYC    (`SCR_TIMEOUT_NS / `SCR_CLK_PERIOD_NS)

`endif

// ==== verilog/scr_pkg.sv ====
package scr_pkg;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RD2  = 1'b1
  } scr_seq_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } scr_wr_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] cmd_crc;
    logic [15:0] data;
    logic [15:0] data_crc;
  } scr_rx_t;

endpackage : scr_pkg

// ==== verilog/scr_core.sv ====
// Functional notes
// RULE1 - Status bits 6:3 report previous frame command.
// RULE2 - Code 0000b is never produced.
// RULE3 - NULL gives 0001b, LOCK gives 0010b.
// RULE4 - First register read frame gives 0100b.
// RULE5 - Read second frame must be NULL, gives 0101b.
// RULE6 - Good register write gives 0110b.
// RULE7 - Codes 0111b and 1000b are never produced.
// RULE8 - Code resets to 1001b for first frame.
// RULE9 - Second frame reports first frame's command.
// RULE10 - Timeout before command check word gives 1010b.
// RULE11 - Too few serial clocks gives 1010b.
// RULE12 - Command check word mismatch gives 1010b.
// RULE13 - Bad data check word blocks write, 1010b.
// RULE14 - Host sends command and check word.
// RULE15 - Reset needs the whole frame clocked.
// RULE16 - Undecodable command with good check: error NULL.
// RULE17 - Non-NULL second read frame: error NULL.
// RULE18 - Status bit 2 shows lock, resets 0.
// RULE19 - Code latched at frame end, held stable.
`timescale 1ns/1ps
`include "scr_defines.svh"
module scr_core (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic [3:0]      resp_code,
  output logic            lock_state,
  output scr_pkg::scr_wr_t reg_wr,
  output logic            reg_wr_valid,
  output logic [7:0]      reg_rd_addr,
  output logic            reg_rd_valid,
  output logic            soft_reset
);

  function automatic logic [15:0] crc16(input logic [15:0] w);
    logic [15:0] c;
    c = `SCR_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ w[i]) ? ((c << 1) ^ `SCR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc16

  // Link domain: receive side, sampled on the rising serial clock.
  logic             new_frame;
  logic             cmd_done;
  logic             next_cmd_done;
  logic             wr_done;
  logic             next_wr_done;
  logic             all_done;
  logic             next_all_done;
  logic [6:0]       bit_cnt;
  logic [6:0]       next_bit_cnt;
  scr_pkg::scr_rx_t rx;
  scr_pkg::scr_rx_t next_rx;
  logic [6:0]       rx_idx;

  always_comb begin
    next_rx = rx;
    rx_idx  = new_frame ? 7'h00 : bit_cnt;
    if (new_frame) begin
      next_bit_cnt = 7'h01;
    end else if (bit_cnt == `SCR_BITS_MAX) begin
      next_bit_cnt = bit_cnt;
    end else begin
      next_bit_cnt = bit_cnt + 7'h01;
    end
    if (rx_idx < `SCR_BITS_RX) begin
      next_rx[6'(7'h3F - rx_idx)] = mosi;
    end
    next_cmd_done = (next_bit_cnt >= `SCR_BITS_CMD);
    next_wr_done  = (next_bit_cnt >= `SCR_BITS_REGISTER_WRITE_CMD);
    next_all_done = (next_bit_cnt >= `SCR_BITS_FRAME);
  end

  always_ff @(posedge sclk) begin
    bit_cnt <= next_bit_cnt;
    rx      <= next_rx;
  end

  // Frame markers are preset while the chip select is high (new_frame set, done flags cleared), so no edge is needed after the frame.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      new_frame <= 1'b1;
      cmd_done  <= 1'b0;
      wr_done   <= 1'b0;
      all_done  <= 1'b0;
    end else begin
      new_frame <= 1'b0;
      cmd_done  <= next_cmd_done;
      wr_done   <= next_wr_done;
      all_done  <= next_all_done;
    end
  end

  // Link domain: transmit side, the status word shifted out on the falling serial clock.
  logic [3:0]  tx_cnt;
  logic [3:0]  next_tx_cnt;
  logic        next_miso;
  logic [15:0] stat_word;

  always_comb begin
    stat_word   = {`SCR_STAT_HI, resp_code, lock_state, `SCR_STAT_LO}; // RULE1 RULE18
    next_tx_cnt = (tx_cnt == 4'hF) ? tx_cnt : tx_cnt + 4'h1;
    next_miso   = (tx_cnt == 4'hF) ? 1'b0 : stat_word[4'hE - tx_cnt];
  end

  // Status bit 15 is 0, so the cleared output already presents it before the first falling clock.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt <= 4'h0;
      miso   <= 1'b0;
    end else begin
      tx_cnt <= next_tx_cnt;
      miso   <= next_miso;
    end
  end

  // System domain: synchronisers and interface timeout.
  logic        cs_s1;
  logic        cs_s2;
  logic        cs_d;
  logic        done_s1;
  logic        done_s2;
  logic [1:0]  lvl_s1;
  logic [1:0]  lvl_s2;
  logic [2:0]  got;
  logic [2:0]  next_got;
  logic [11:0] to_cnt;
  logic [11:0] next_to_cnt;
  logic        to_flag;
  logic        next_to_flag;
  logic        frame_end;

  assign frame_end = cs_s2 & ~cs_d;

  always_comb begin
    next_to_cnt  = to_cnt;
    next_to_flag = to_flag;
    // Levels and select share one synchroniser depth, so the last values seen with the select low are final.
    next_got     = cs_s2 ? got : {lvl_s2, done_s2};
    if (cs_s2 && cs_d) begin
      next_to_cnt  = 12'h000;
      next_to_flag = 1'b0;
    end else if (!cs_s2) begin
      if (to_cnt != 12'(`SCR_TIMEOUT_CYC - 1)) begin
        next_to_cnt = to_cnt + 12'h001;
      end else if (!done_s2) begin
        next_to_flag = 1'b1; // RULE10
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_d    <= 1'b1;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      lvl_s1  <= 2'h0;
      lvl_s2  <= 2'h0;
      got     <= 3'h0;
      to_cnt  <= 12'h000;
      to_flag <= 1'b0;
    end else begin
      cs_s1   <= cs_n;
      cs_s2   <= cs_s1;
      cs_d    <= cs_s2;
      done_s1 <= cmd_done;
      done_s2 <= done_s1;
      lvl_s1  <= {all_done, wr_done};
      lvl_s2  <= lvl_s1;
      got     <= next_got;
      to_cnt  <= next_to_cnt;
      to_flag <= next_to_flag;
    end
  end

  // System domain: frame evaluation. The link registers are still while the chip select is high.
  logic              cmd_crc_ok;
  logic              data_crc_ok;
  logic              is_rd;
  logic              is_wr;
  logic              fail;
  scr_pkg::scr_seq_t seq;
  scr_pkg::scr_seq_t next_seq;
  logic [3:0]        next_resp;
  logic              next_lock;
  scr_pkg::scr_wr_t  next_wr;
  logic              next_wr_valid;
  logic [7:0]        next_rd_addr;
  logic              next_rd_valid;
  logic              next_soft;

  always_comb begin
    cmd_crc_ok  = (crc16(rx.cmd) == rx.cmd_crc);
    data_crc_ok = (crc16(rx.data) == rx.data_crc);
    is_rd       = (rx.cmd[15:13] == `SCR_OP_REGISTER_READ_CMD);
    is_wr       = (rx.cmd[15:13] == `SCR_OP_REGISTER_WRITE_CMD);
    fail        = ~got[0] | to_flag | ~cmd_crc_ok; // RULE10 RULE11 RULE12 RULE14
  end

  always_comb begin
    next_resp     = resp_code;
    next_lock     = lock_state;
    next_seq      = seq;
    next_wr       = reg_wr;
    next_wr_valid = 1'b0;
    next_rd_addr  = reg_rd_addr;
    next_rd_valid = 1'b0;
    next_soft     = 1'b0;
    if (frame_end) begin // RULE19
      next_seq = scr_pkg::SEQ_IDLE;
      if (fail) begin
        next_resp = `SCR_RESP_ERR; // RULE10 RULE11 RULE12
      end else if (seq == scr_pkg::SEQ_RD2) begin
        next_resp = (rx.cmd == `SCR_CMD_NULL) ? `SCR_RESP_RREG2 : `SCR_RESP_ERR; // RULE5 RULE17
      end else if (rx.cmd == `SCR_CMD_NULL) begin
        next_resp = `SCR_RESP_NULL; // RULE3 RULE9
      end else if (rx.cmd == `SCR_CMD_LOCK) begin
        next_resp = `SCR_RESP_LOCK; // RULE3
        next_lock = 1'b1; // RULE18
      end else if (rx.cmd == `SCR_CMD_UNLOCK) begin
        next_resp = `SCR_RESP_UNLOCK;
        next_lock = 1'b0; // RULE18
      end else if (rx.cmd == `SCR_CMD_RESET) begin
        if (got[2]) begin // RULE15
          next_resp = `SCR_RESP_FIRST; // RULE8
          next_lock = `SCR_LOCK_RST;
          next_soft = 1'b1;
        end else begin
          next_resp = `SCR_RESP_ERR; // RULE11
        end
      end else if (is_rd) begin
        next_resp     = `SCR_RESP_REGISTER_READ_CMD; // RULE4
        next_seq      = scr_pkg::SEQ_RD2; // RULE5
        next_rd_addr  = rx.cmd[12:5];
        next_rd_valid = 1'b1;
      end else if (is_wr) begin
        if (!got[1] || !data_crc_ok) begin
          next_resp = `SCR_RESP_ERR; // RULE11 RULE13
        end else begin
          next_resp     = `SCR_RESP_REGISTER_WRITE_CMD; // RULE6
          next_wr.addr  = rx.cmd[12:5];
          next_wr.data  = rx.data;
          next_wr_valid = 1'b1;
        end
      end else begin
        next_resp = `SCR_RESP_ERR; // RULE16
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      resp_code    <= `SCR_RESP_RST; // RULE8
      lock_state   <= `SCR_LOCK_RST; // RULE18
      seq          <= scr_pkg::SEQ_IDLE;
      reg_wr       <= '0;
      reg_wr_valid <= 1'b0;
      reg_rd_addr  <= 8'h00;
      reg_rd_valid <= 1'b0;
      soft_reset   <= 1'b0;
    end else begin
      resp_code    <= next_resp;
      lock_state   <= next_lock;
      seq          <= next_seq;
      reg_wr       <= next_wr;
      reg_wr_valid <= next_wr_valid;
      reg_rd_addr  <= next_rd_addr;
      reg_rd_valid <= next_rd_valid;
      soft_reset   <= next_soft;
    end
  end

  // Checks.
  localparam int TO_LAST = `SCR_TIMEOUT_CYC - 1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_good_idle;
    frame_end && !fail && seq == scr_pkg::SEQ_IDLE;
  endsequence
  sequence s_rd2_null;
    frame_end && !fail && seq == scr_pkg::SEQ_RD2 && rx.cmd == `SCR_CMD_NULL;
  endsequence

  resp_legal_a: assert property (resp_code != 4'h0) else $error("zero response code"); // RULE2
  resp_reserved_a: assert property (resp_code != 4'h7 && resp_code != 4'h8) // RULE7
    else $error("reserved response code");
  resp_hold_a: assert property (!frame_end |=> $stable(resp_code) && $stable(lock_state)) // RULE19
    else $error("response changed outside frame end");
  first_frame_a: assert property (!$past(nrst) |-> resp_code == `SCR_RESP_FIRST && !lock_state) // RULE8
    else $error("bad reset response");
  null_resp_a: assert property (s_good_idle and rx.cmd == `SCR_CMD_NULL |=> resp_code == `SCR_RESP_NULL) // RULE3
    else $error("null response wrong");
  lock_resp_a: assert property (s_good_idle and rx.cmd == `SCR_CMD_LOCK // RULE18
    |=> resp_code == `SCR_RESP_LOCK && lock_state)
    else $error("lock response wrong");
  rd_first_a: assert property (s_good_idle and is_rd // RULE4
    |=> resp_code == `SCR_RESP_REGISTER_READ_CMD && reg_rd_valid ##1 !reg_rd_valid)
    else $error("read first frame wrong");
  rd_second_a: assert property (s_rd2_null |=> resp_code == `SCR_RESP_RREG2 && seq == scr_pkg::SEQ_IDLE) // RULE5
    else $error("read second frame wrong");
  rd_bad_a: assert property (frame_end && seq == scr_pkg::SEQ_RD2 && rx.cmd != `SCR_CMD_NULL // RULE17
    |=> resp_code == 4'hA)
    else $error("read second frame not refused");
  err_resp_a: assert property (frame_end && fail |=> resp_code == `SCR_RESP_ERR && !reg_wr_valid) // RULE10
    else $error("failed frame not reported");
  wr_ok_a: assert property (s_good_idle and is_wr && data_crc_ok && got[1] // RULE6
    |=> resp_code == `SCR_RESP_REGISTER_WRITE_CMD && reg_wr_valid && reg_wr.data == $past(rx.data))
    else $error("write not applied");
  wr_crc_a: assert property (s_good_idle and is_wr && !data_crc_ok |=> resp_code == 4'hA && !reg_wr_valid) // RULE13
    else $error("bad write data applied");
  timeout_a: assert property (!cs_s2 && to_cnt == 12'(TO_LAST) && !done_s2 |=> to_flag) // RULE10
    else $error("timeout not flagged");

endmodule : scr_core

// ==== bench/scr_host.sv ====
`timescale 1ns/1ps
module scr_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    #1;
    cs_n = 1'b1;
  end

  // Holds the frame open for 24 + hold ns and then shifts n bits MSB first.
  task automatic frame(input logic [79:0] w, input int n, input int hold, output logic [15:0] st);
    st   = 16'h0000;
    cs_n = 1'b0;
    #(24 + hold);
    for (int i = 0; i < n; i++) begin
      mosi = w[79-i];
      #24;
      sclk = 1'b1;
      if (i < 16) begin
        st[15-i] = miso;
      end
      #24;
      sclk = 1'b0;
    end
    #24;
    cs_n = 1'b1;
    mosi = ~mosi;
    #100;
  endtask : frame
endmodule : scr_host

// ==== bench/tb_spi_command_response_status.sv ====
`timescale 1ns/1ps
`include "scr_defines.svh"
module tb_spi_command_response_status;
  logic                clk_sys = 1'b0;
  logic                nrst    = 1'b0;
  logic                sclk;
  logic                cs_n;
  logic                mosi;
  logic                miso;
  logic [3:0]          resp_code;
  logic                lock_state;
  scr_pkg::scr_wr_t    reg_wr;
  logic                reg_wr_valid;
  logic [7:0]          reg_rd_addr;
  logic                reg_rd_valid;
  logic                soft_reset;
  int                  n_sr     = 0;
  int                  n_fail   = 0;
  int                  n_checks = 0;
  int                  n_wr     = 0;
  int                  n_rd     = 0;
  logic [3:0]          pr       = 4'h9;
  logic                pl       = 1'b0;

  always #2.5 clk_sys = ~clk_sys;

  scr_core u_scr_core (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .resp_code(resp_code), .lock_state(lock_state), .reg_wr(reg_wr), .reg_wr_valid(reg_wr_valid),
    .reg_rd_addr(reg_rd_addr), .reg_rd_valid(reg_rd_valid), .soft_reset(soft_reset));
  scr_host u_scr_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  always @(posedge clk_sys) begin
    n_wr += (reg_wr_valid === 1'b1);
    n_rd += (reg_rd_valid === 1'b1);
    n_sr += (soft_reset === 1'b1);
    if (nrst === 1'b1 && (resp_code === 4'h0 || resp_code === 4'h7 || resp_code === 4'h8)) begin
      chk(1'b0, "reserved response code");
    end
  end

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  function automatic logic [15:0] crc(input logic [15:0] d);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc

  // Runs one frame, checks the shifted status and the code latched at its end.
  task automatic run(input string nm, input logic [15:0] c, input logic [15:0] d, input int n, input int hold,
                     input logic [79:0] bad, input logic [3:0] er, input logic el);
    logic [15:0] st;
    u_scr_host.frame({c, crc(c), d, crc(d), 16'h0000} ^ bad, n, hold, st);
    if (n >= 16) begin
      chk(st === {9'h0FF, pr, pl, 2'b00}, "status word");
    end
    repeat (10) @(posedge clk_sys);
    chk(resp_code === er, "response code");
    chk(lock_state === el, "lock state");
    pr = er;
    pl = el;
    $display("test %s done", nm);
  endtask : run

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #150000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(resp_code === 4'h9 && lock_state === 1'b0, "reset values");
    run("first", `SCR_CMD_NULL, 16'h0, 32, 0, 80'h0, 4'h1, 1'b0);
    run("lock", `SCR_CMD_LOCK, 16'h0, 32, 0, 80'h0, 4'h2, 1'b1);
    run("read", 16'hA240, 16'h0, 32, 0, 80'h0, 4'h4, 1'b1);
    chk(reg_rd_addr === 8'h12 && n_rd == 1, "read address");
    run("read2", `SCR_CMD_NULL, 16'h0, 32, 0, 80'h0, 4'h5, 1'b1);
    run("read", 16'hA240, 16'h0, 32, 0, 80'h0, 4'h4, 1'b1);
    run("badread2", `SCR_CMD_LOCK, 16'h0, 32, 0, 80'h0, 4'hA, 1'b1);
    run("write", 16'h6680, 16'hBEEF, 64, 0, 80'h0, 4'h6, 1'b1);
    chk(reg_wr === {8'h34, 16'hBEEF} && n_wr == 1, "write applied");
    run("baddata", 16'h6680, 16'h1234, 64, 0, {48'h0, 16'h0001, 16'h0}, 4'hA, 1'b1);
    chk(reg_wr === {8'h34, 16'hBEEF} && n_wr == 1, "write blocked");
    run("badcrc", `SCR_CMD_NULL, 16'h0, 32, 0, {16'h0, 16'h0100, 48'h0}, 4'hA, 1'b1);
    run("short", `SCR_CMD_UNLOCK, 16'h0, 20, 0, 80'h0, 4'hA, 1'b1);
    run("invalid", 16'h1234, 16'h0, 32, 0, 80'h0, 4'hA, 1'b1);
    run("unlock", `SCR_CMD_UNLOCK, 16'h0, 32, 0, 80'h0, 4'h3, 1'b0);
    run("lock", `SCR_CMD_LOCK, 16'h0, 32, 0, 80'h0, 4'h2, 1'b1);
    run("shortrst", `SCR_CMD_RESET, 16'h0, 32, 0, 80'h0, 4'hA, 1'b1);
    chk(n_sr == 0, "short reset applied");
    run("reset", `SCR_CMD_RESET, 16'h0, 80, 0, 80'h0, 4'h9, 1'b0);
    chk(n_sr == 1, "soft reset pulse");
    run("timeout", `SCR_CMD_NULL, 16'h0, 32, 21000, 80'h0, 4'hA, 1'b0);
    run("null", `SCR_CMD_NULL, 16'h0, 32, 0, 80'h0, 4'h1, 1'b0);
    print_verdict();
  end
endmodule : tb_spi_command_response_status
